// ==== verilog/cim_cfg.svh ====
// constants for the card interface mask, config and status register slice
`ifndef CIM_CFG_SVH
`define CIM_CFG_SVH

// ----------------------------------------
// bus addresses
// ----------------------------------------
`define CIM_ADDR_W 28
`define CIM_INT_STATUS_ADDR 28'hB0008F8
`define CIM_INT_MASK_ADDR 28'hB0008FA
`define CIM_WAIT_CFG_ADDR 28'hB0008FE
`define CIM_INDEX_ADDR 28'hB0008E0
`define CIM_DATA_ADDR 28'hB0008E2

// ----------------------------------------
// indexed register numbers
// ----------------------------------------
`define CIM_IDX_IDENT 8'h00
`define CIM_IDX_STATUS 8'h01

// ----------------------------------------
// field layouts and reset values
// ----------------------------------------
`define CIM_MASK_VALID 16'hDEB8
`define CIM_MASK_RESET 16'h0000
`define CIM_WAIT_BIT 0
`define CIM_WAIT_RESET 1'b1
`define CIM_IFTYPE_VALUE 2'h2
// revision code is arbitrary
`define CIM_REVISION_VALUE 4'h5
`define CIM_STAT_RSVD_HI 7
`define CIM_STAT_POWER 6
`define CIM_STAT_READY 5
`define CIM_STAT_WPROT 4
`define CIM_STAT_CD2 3
`define CIM_STAT_CD1 2
`define CIM_STAT_CHANGE 0
`define CIM_INDEX_RESET 8'h00

`endif

// ==== verilog/cim_pkg.sv ====
// types for the card interface mask, config and status register slice
package cim_pkg;

  // ----------------------------------------
  // bus access sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    CIM_IDLE = 3'b001,
    CIM_WAIT = 3'b010,
    CIM_DONE = 3'b100
  } cim_state_type;

endpackage

// ==== verilog/cim_regs.sv ====
// card interface mask, wait config, identification and status registers
`timescale 1ns/100ps
`default_nettype none
`include "cim_cfg.svh"

module cim_regs
  import cim_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic BUS_REQ,
  input wire logic BUS_WR,
  input wire logic [27:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  output logic BUS_ACK,
  output logic [15:0] BUS_RDATA,
  input wire logic [15:0] IRQ_REQ,
  output logic CPU_INT,
  input wire logic SOCKET_POWER_ON,
  input wire logic CD_PINS_SELECTED,
  input wire logic CARD_BUSY_PIN_N,
  input wire logic CARD_IO_WIDTH_PIN_N,
  input wire logic CARD_STATUS_CHANGE_PIN_N,
  input wire logic CARD_DETECT_PIN_ONE_N,
  input wire logic CARD_DETECT_PIN_TWO_N,
  output logic WAIT_STATE_ENABLE
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // keeps only implemented request positions
  function automatic logic [15:0] valid_bits(input logic [15:0] v);
    valid_bits = v & `CIM_MASK_VALID;
  endfunction

  // places the four mask fields at their request positions, zeros elsewhere
  function automatic logic [15:0] mask_word(input logic [1:0] hi, input logic [3:0] mid,
    input logic seven, input logic [2:0] lo);
    mask_word = {hi, 1'b0, mid, 1'b0, seven, 1'b0, lo, 3'h0};
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  cim_state_type state_q;
  cim_state_type state_d;
  logic [27:0] addr_q;
  logic wr_q;
  logic [15:0] wdata_q;
  localparam logic [15:0] mask_reset_word = `CIM_MASK_RESET;
  logic [1:0] request_mask_high_q;
  logic [3:0] request_mask_mid_q;
  logic request_mask_seven_q;
  logic [2:0] request_mask_low_q;
  logic [15:0] card_interrupt_mask;
  logic peripheral_wait_state_enable_q;
  logic [7:0] index_q;
  logic socket_power_state_q;
  logic [15:0] card_interrupt_status;
  logic [7:0] card_ident_revision;
  logic [7:0] card_interface_status;
  logic [1:0] card_detect_bits;
  logic [15:0] read_mux;
  logic do_write;
  logic take;
  logic closing;
  logic hit_mask;
  logic hit_wait;
  logic hit_index;
  logic mask_we;
  logic wait_we;
  logic index_we;
  logic card_ready_state;
  logic write_protect_state;
  logic status_change_level;
  logic [1:0] interface_type_field;
  logic [3:0] revision_level_field;
  logic [15:0] unmasked_requests;

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  // one extra cycle when the wait state is enabled
  always_comb begin
    state_d = state_q;
    case (state_q)
      CIM_IDLE: begin
        if (BUS_REQ) begin
          state_d = peripheral_wait_state_enable_q ? CIM_WAIT : CIM_DONE;
        end
      end
      CIM_WAIT: begin
        state_d = CIM_DONE;
      end
      CIM_DONE: begin
        state_d = CIM_IDLE;
      end
      default: begin
        state_d = CIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= CIM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // requests while busy are ignored, so the latch only loads in idle
  assign take = (state_q == CIM_IDLE) && BUS_REQ;
  assign closing = (state_q == CIM_DONE);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      addr_q <= 28'h0000000;
    end else if (take) begin
      addr_q <= BUS_ADDR;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_q <= 1'b0;
    end else if (take) begin
      wr_q <= BUS_WR;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wdata_q <= 16'h0000;
    end else if (take) begin
      wdata_q <= BUS_WDATA;
    end
  end

  assign do_write = closing && wr_q;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // full 28-bit compare; status and data words have no write enable: read-only
  always_comb begin
    hit_mask = (addr_q == `CIM_INT_MASK_ADDR);
    hit_wait = (addr_q == `CIM_WAIT_CFG_ADDR);
    hit_index = (addr_q == `CIM_INDEX_ADDR);
    mask_we = do_write && hit_mask;
    wait_we = do_write && hit_wait;
    index_we = do_write && hit_index;
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      request_mask_high_q <= mask_reset_word[15:14];
    end else if (mask_we) begin
      request_mask_high_q <= wdata_q[15:14];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      request_mask_mid_q <= mask_reset_word[12:9];
    end else if (mask_we) begin
      request_mask_mid_q <= wdata_q[12:9];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      request_mask_seven_q <= mask_reset_word[7];
    end else if (mask_we) begin
      request_mask_seven_q <= wdata_q[7];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      request_mask_low_q <= mask_reset_word[5:3];
    end else if (mask_we) begin
      request_mask_low_q <= wdata_q[5:3];
    end
  end

  // reserved positions have no storage, so they read zero and ignore writes
  assign card_interrupt_mask = mask_word(request_mask_high_q, request_mask_mid_q,
    request_mask_seven_q, request_mask_low_q);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      peripheral_wait_state_enable_q <= `CIM_WAIT_RESET;
    end else if (wait_we) begin
      peripheral_wait_state_enable_q <= wdata_q[`CIM_WAIT_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      index_q <= `CIM_INDEX_RESET;
    end else if (index_we) begin
      index_q <= wdata_q[7:0];
    end
  end

  // ----------------------------------------
  // live card state
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      socket_power_state_q <= 1'b0;
    end else begin
      socket_power_state_q <= SOCKET_POWER_ON;
    end
  end

  // a half-seated card reads as absent while CD_PINS_SELECTED is high (unselected reads 3); software never sees mixed bits
  always_comb begin
    if (!CD_PINS_SELECTED) begin
      card_detect_bits = 2'h3;
    end else if (!CARD_DETECT_PIN_ONE_N && !CARD_DETECT_PIN_TWO_N) begin
      card_detect_bits = 2'h3;
    end else begin
      card_detect_bits = 2'h0;
    end
  end

  // pins are taken as synchronous, so the levels go straight to the read mux
  always_comb begin
    card_ready_state = CARD_BUSY_PIN_N;
    write_protect_state = !CARD_IO_WIDTH_PIN_N;
    status_change_level = CARD_STATUS_CHANGE_PIN_N;
  end

  always_comb begin
    card_interface_status = 8'h00;
    card_interface_status[`CIM_STAT_RSVD_HI] = 1'b1;
    card_interface_status[`CIM_STAT_POWER] = socket_power_state_q;
    card_interface_status[`CIM_STAT_READY] = card_ready_state;
    card_interface_status[`CIM_STAT_WPROT] = write_protect_state;
    card_interface_status[`CIM_STAT_CD2] = card_detect_bits[1];
    card_interface_status[`CIM_STAT_CD1] = card_detect_bits[0];
    card_interface_status[`CIM_STAT_CHANGE] = status_change_level;
  end

  assign interface_type_field = `CIM_IFTYPE_VALUE;
  assign revision_level_field = `CIM_REVISION_VALUE;
  assign card_ident_revision = {interface_type_field, 2'h0, revision_level_field};

  assign card_interrupt_status = valid_bits(IRQ_REQ);

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    read_mux = 16'h0000;
    case (addr_q)
      `CIM_INT_STATUS_ADDR: begin
        read_mux = card_interrupt_status;
      end
      `CIM_INT_MASK_ADDR: begin
        read_mux = card_interrupt_mask;
      end
      `CIM_WAIT_CFG_ADDR: begin
        read_mux = {15'h0000, peripheral_wait_state_enable_q};
      end
      `CIM_INDEX_ADDR: begin
        read_mux = {8'h00, index_q};
      end
      `CIM_DATA_ADDR: begin
        if (index_q == `CIM_IDX_IDENT) begin
          read_mux = {8'h00, card_ident_revision};
        end else if (index_q == `CIM_IDX_STATUS) begin
          read_mux = {8'h00, card_interface_status};
        end else begin
          read_mux = 16'h0000;
        end
      end
      default: begin
        read_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BUS_ACK <= 1'b0;
    end else begin
      BUS_ACK <= closing;
    end
  end

  // read data holds between reads so a slow master can still pick it up
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BUS_RDATA <= 16'h0000;
    end else if (closing && !wr_q) begin
      BUS_RDATA <= read_mux;
    end
  end

  // ----------------------------------------
  // outputs to the processor side
  // ----------------------------------------
  // raw status stays visible; only the forwarded line is gated
  assign unmasked_requests = card_interrupt_status & ~card_interrupt_mask;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CPU_INT <= 1'b0;
    end else begin
      CPU_INT <= |unmasked_requests;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      WAIT_STATE_ENABLE <= `CIM_WAIT_RESET;
    end else begin
      WAIT_STATE_ENABLE <= peripheral_wait_state_enable_q;
    end
  end

endmodule
`default_nettype wire

// ==== bench/cim_card.sv ====
// card model on the far side of the socket pins
`timescale 1ns/100ps
`default_nettype none
module cim_card (
  input wire logic ins,
  input wire logic half,
  input wire logic bsy,
  input wire logic prot,
  input wire logic chg,
  output logic busy_n,
  output logic io_n,
  output logic chg_n,
  output logic cd1_n,
  output logic cd2_n
);
  // a half-seated card makes only the first detect contact
  assign cd1_n = !ins;
  assign cd2_n = !(ins && !half);
  // empty socket: pull-ups hold pins high
  assign busy_n = !(ins && bsy);
  assign io_n = !(ins && prot);
  assign chg_n = !(ins && chg);
endmodule
`default_nettype wire

// ==== bench/cim_regs_sva.sv ====
// assertions on the card interface register slice
`timescale 1ns/100ps
`default_nettype none
module cim_regs_sva
  import cim_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic BUS_REQ,
  input wire logic BUS_ACK,
  input wire logic [15:0] BUS_RDATA,
  input wire logic [15:0] IRQ_REQ,
  input wire logic CPU_INT,
  input wire logic WAIT_STATE_ENABLE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ack_pulse_a: assert property (BUS_ACK |=> !BUS_ACK) else $error("ack too long");
  fast_ack_a: assert property (BUS_REQ && !WAIT_STATE_ENABLE |-> ##1 !BUS_ACK ##1 BUS_ACK)
    else $error("ack late");
  slow_ack_a: assert property (BUS_REQ && WAIT_STATE_ENABLE |->
    ##1 !BUS_ACK [*2] ##1 BUS_ACK) else $error("wait missing");
  ack_cause_a: assert property (BUS_ACK |-> $past(BUS_REQ, 2) || $past(BUS_REQ, 3))
    else $error("stray ack");
  rst_wait_a: assert property ($fell(RST) |-> WAIT_STATE_ENABLE) else $error("wait rst");
  rst_idle_a: assert property ($fell(RST) |-> !CPU_INT && !BUS_ACK) else $error("rst");
  rdata_hold_a: assert property (!BUS_ACK |-> $stable(BUS_RDATA)) else $error("rdata");
  no_fwd_a: assert property ((IRQ_REQ & 16'hDEB8) == 16'h0000 |=> !CPU_INT)
    else $error("int without request");
  int_cause_a: assert property (CPU_INT |-> $past(|(IRQ_REQ & 16'hDEB8)))
    else $error("int cause");
  cover property (BUS_ACK && WAIT_STATE_ENABLE);
  cover property (BUS_ACK && !WAIT_STATE_ENABLE);
  cover property (CPU_INT);
endmodule
bind cim_regs cim_regs_sva i_cim_regs_sva (.SYS_CLK(SYS_CLK), .RST(RST), .BUS_REQ(BUS_REQ),
  .BUS_ACK(BUS_ACK), .BUS_RDATA(BUS_RDATA), .IRQ_REQ(IRQ_REQ), .CPU_INT(CPU_INT),
  .WAIT_STATE_ENABLE(WAIT_STATE_ENABLE));
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the card interface register slice
`timescale 1ns/100ps
`default_nettype none
`include "cim_cfg.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [27:0] addr = 28'h0000000;
  logic [15:0] wd = 16'h0000;
  logic [15:0] irq = 16'h0000;
  logic pwr = 1'b0, sel = 1'b0, ins = 1'b0, bsy = 1'b0, prot = 1'b0, chg = 1'b0, half = 1'b0;
  logic ack, cint, peripheral_wait_state_enable, bn, ion, cn, d1, d2;
  logic [15:0] rd, m, v;
  logic [16:0] q[$];
  logic [16:0] n;
  int bad_count = 0;
  int cmp_count = 0;
  cim_regs i_cim_regs (.SYS_CLK(clk), .RST(rst), .BUS_REQ(req), .BUS_WR(wr), .BUS_ADDR(addr),
    .BUS_WDATA(wd), .BUS_ACK(ack), .BUS_RDATA(rd), .IRQ_REQ(irq), .CPU_INT(cint),
    .SOCKET_POWER_ON(pwr), .CD_PINS_SELECTED(sel), .CARD_BUSY_PIN_N(bn),
    .CARD_IO_WIDTH_PIN_N(ion), .CARD_STATUS_CHANGE_PIN_N(cn), .CARD_DETECT_PIN_ONE_N(d1),
    .CARD_DETECT_PIN_TWO_N(d2), .WAIT_STATE_ENABLE(peripheral_wait_state_enable));
  cim_card i_cim_card (.ins(ins), .half(half), .bsy(bsy), .prot(prot), .chg(chg),
    .busy_n(bn), .io_n(ion), .chg_n(cn), .cd1_n(d1), .cd2_n(d2));
  initial begin
    forever #12.5 clk = !clk;
  end
  // ----
  // checks and bus cycles
  // ----
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // request is a single pulse: held high it would be taken again
  task automatic acc(input logic w, input logic [27:0] a, input logic [15:0] d,
    input logic [15:0] e);
    int i;
    q.push_back({!w, e});
    @(posedge clk);
    #2;
    req = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(posedge clk);
    #2;
    req = 1'b0;
    for (i = 0; i < 6 && ack !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    if (ack !== 1'b1) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic rx(input logic [7:0] x, input logic [15:0] e);
    acc(1'b1, `CIM_INDEX_ADDR, {8'h00, x}, 16'h0000);
    acc(1'b0, `CIM_DATA_ADDR, 16'h0000, e);
  endtask
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      n = q.pop_front();
      if (n[16]) begin
        chk("read data", n[15:0], rd);
      end
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(32'h869A));
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    v = {8'h00, `CIM_IFTYPE_VALUE, 2'b00, `CIM_REVISION_VALUE};
    acc(1'b0, `CIM_INT_MASK_ADDR, 16'h0000, 16'h0000);
    acc(1'b0, `CIM_WAIT_CFG_ADDR, 16'h0000, 16'h0001);
    rx(`CIM_IDX_IDENT, v);
    acc(1'b1, `CIM_DATA_ADDR, 16'hFFFF, 16'h0000);
    acc(1'b0, `CIM_DATA_ADDR, 16'h0000, v);
    acc(1'b0, 28'h0000100, 16'h0000, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      m = (k == 0) ? 16'hFFFF : 16'($urandom);
      acc(1'b1, `CIM_INT_MASK_ADDR, m, 16'h0000);
      acc(1'b0, `CIM_INT_MASK_ADDR, 16'h0000, m & `CIM_MASK_VALID);
      irq = 16'($urandom);
      repeat (2) @(posedge clk);
      #2;
      chk("cpu int", {15'h0000, |(irq & ~m & `CIM_MASK_VALID)}, {15'h0000, cint});
      acc(1'b0, `CIM_INT_STATUS_ADDR, 16'h0000, irq & `CIM_MASK_VALID);
    end
    acc(1'b1, `CIM_WAIT_CFG_ADDR, 16'hFFFE, 16'h0000);
    acc(1'b0, `CIM_WAIT_CFG_ADDR, 16'h0000, 16'h0000);
    chk("wait out", 16'h0000, {15'h0000, peripheral_wait_state_enable});
    acc(1'b1, `CIM_WAIT_CFG_ADDR, 16'hFFFF, 16'h0000);
    acc(1'b0, `CIM_WAIT_CFG_ADDR, 16'h0000, 16'h0001);
    chk("wait out", 16'h0001, {15'h0000, peripheral_wait_state_enable});
    for (int k = 0; k < 16; k++) begin
      {pwr, sel, ins, bsy, prot, chg, half} = 7'($urandom);
      rx(`CIM_IDX_STATUS, {8'h00, 1'b1, pwr, !(ins && bsy), ins && prot,
        {2{!sel || (ins && !half)}}, 1'b0, !(ins && chg)});
    end
    acc(1'b0, `CIM_INDEX_ADDR, 16'h0000, {8'h00, `CIM_IDX_STATUS});
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
